// >>> rtl/clock_mode_pkg.sv
// Constants and carrier types for the clock and operating-mode controller.
// Assumes one 100 MHz system clock and a plain register port.
package clock_mode_pkg;

    localparam logic [7:0] osc_mode_ctrl_addr = 8'h95;
    localparam logic [7:0] irq_status_addr = 8'h96;
    localparam logic [7:0] irq_mask_addr = 8'h97;
    localparam logic [7:0] osc_status_addr = 8'h98;

    localparam int high_osc_stop_pos = 1;
    localparam int clock_mode_pos = 2;
    localparam int cpu_mode_lo_pos = 3;
    localparam int cpu_mode_hi_pos = 4;
    localparam logic [7:0] osc_mode_used_mask = 8'h1e;
    localparam logic [7:0] osc_mode_reset = 8'h00;

    localparam int wake_flag_pos = 0;
    localparam int ready_flag_pos = 1;
    localparam logic [1:0] irq_reset = 2'h0;

    localparam logic [1:0] cpu_mode_normal = 2'h0;
    localparam logic [1:0] cpu_mode_power_down = 2'h1;
    localparam logic [1:0] cpu_mode_green = 2'h2;

    localparam int slow_rc_hz = 16000;
    localparam int sys_clk_hz = 100000000;
    localparam int slow_rc_div = sys_clk_hz / slow_rc_hz;
    localparam int warm_reset_clocks = 2048;
    localparam int warm_xtal_clocks = 2048;
    localparam int warm_rc_clocks = 32;

    typedef enum logic [3:0]
    {
        st_warm = 4'b0001,
        st_run = 4'b0010,
        st_green = 4'b0100,
        st_power_down = 4'b1000
    } mode_state_t;

    typedef struct packed
    {
        logic cpu_run;
        logic sys_clk_slow;
        logic fast_osc_on;
        logic slow_rc_on;
        logic rtc_xtal_on;
        logic timers_on;
        logic interrupts_on;
        logic serial_clock_on;
    } clock_ctrl_t;

endpackage : clock_mode_pkg

// >>> rtl/system_clock_mode_control.sv
// Clock and operating-mode controller: mode register, warm-up counting,
// oscillator enables and instruction-clock enable for an 8-bit core.
// Assumes the high-speed oscillator clock arrives as a one-cycle pulse
// fast_osc_tick, synchronous to sys_clk, and the core is clocked by
// sys_clk gated with cpu_tick.
// Register port: a write takes effect at its strobe edge; read data
// stand for the one cycle after the read strobe.
// Function
// - Provide 16 kHz slow clock for watchdog, slow mode.
// - Slow instruction clock is slow clock over 1-8.
// - Slow oscillator stops in power-down without watchdog.
// - One 8-bit control register, four used bits.
// - Stop bit halts fast oscillator, slow keeps running.
// - Clock mode bit selects fast or slow clock.
// - Mode field: 00 normal, 01 power-down, 10 green.
// - Stop bit effect depends on oscillator option; here it stops the fast oscillator alike under every option.
// - Wait 2048 fast clocks after any reset.
// - Power-down wake waits 2048 crystal or 32 RC.
// - Enter normal mode and run after reset.
// - Serial ports lose their clock in slow, green.
// - Slow mode leaves fast oscillator running.
// - Green wake returns to the previous mode.
// - Power-down wake always goes to normal mode.
// - Wake clears the mode field and sets flag.
`timescale 1ns/10ps

module system_clock_mode_control
    import clock_mode_pkg::*;
#(
    parameter int slow_div_ratio = 1,
    parameter logic osc_is_rc = 1'b1,
    parameter logic osc_is_internal = 1'b1,
    parameter logic rtc_option = 1'b0,
    parameter logic watchdog_enabled = 1'b1
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic fast_osc_tick,
    input wire logic port_wake,
    input wire logic timer_overflow,
    output logic cpu_tick,
    output logic slow_rc_tick,
    output clock_ctrl_t clock_ctrl,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register and state declarations.

    logic high_osc_stop_reg;
    logic clock_mode_reg;
    logic [1:0] cpu_mode_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    mode_state_t state_reg;
    logic [11:0] warm_cnt_reg;
    logic [11:0] warm_target_reg;
    logic [$clog2(slow_rc_div)-1:0] rc_cnt_reg;
    logic [2:0] slow_div_cnt_reg;
    logic wake_event;
    logic ready_event;
    logic ctrl_write;
    logic [7:0] ctrl_read;
    logic pd_wake;
    logic green_wake;
    logic slow_cpu_tick;
    logic fast_cpu_tick;
    logic [1:0] irq_clear;
    logic [1:0] irq_set;

    assign ctrl_write = reg_wr && (reg_addr == osc_mode_ctrl_addr);
    assign ctrl_read = {3'h0, cpu_mode_reg, clock_mode_reg,
                        high_osc_stop_reg, 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // Slow RC oscillator model: a divider of the system clock.
    // It stands still in power-down unless the watchdog needs it.
    // The rate is exact here, where a real RC drifts with supply and
    // temperature; software must not time anything precise from it.

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rc_cnt_reg <= '0;
            slow_rc_tick <= 1'b0;
        end
        else if (!clock_ctrl.slow_rc_on)
        begin
            slow_rc_tick <= 1'b0;
        end
        else if (rc_cnt_reg == ($clog2(slow_rc_div))'(slow_rc_div - 1))
        begin
            rc_cnt_reg <= '0;
            slow_rc_tick <= 1'b1;
        end
        else
        begin
            rc_cnt_reg <= rc_cnt_reg + 1'b1;
            slow_rc_tick <= 1'b0;
        end
    end

    // Slow-mode instruction clock divider; the ratio is a build option.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            slow_div_cnt_reg <= 3'h0;
        end
        else if (slow_rc_tick)
        begin
            if (slow_div_cnt_reg == 3'(slow_div_ratio - 1))
            begin
                slow_div_cnt_reg <= 3'h0;
            end
            else
            begin
                slow_div_cnt_reg <= slow_div_cnt_reg + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode control register. Software writes it only while the core runs,
    // and hardware changes it only on wake-up, so the two never collide.

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            high_osc_stop_reg <= osc_mode_reset[high_osc_stop_pos];
            clock_mode_reg <= osc_mode_reset[clock_mode_pos];
        end
        else if (pd_wake)
        begin
            // Normal mode after power-down needs the fast oscillator.
            clock_mode_reg <= 1'b0;
            high_osc_stop_reg <= 1'b0;
        end
        else if (ctrl_write && state_reg == st_run)
        begin
            high_osc_stop_reg <= reg_wdata[high_osc_stop_pos];
            clock_mode_reg <= reg_wdata[clock_mode_pos];
        end
    end

    // The mode field is a request that hardware withdraws on wake-up.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cpu_mode_reg <= osc_mode_reset[cpu_mode_hi_pos:cpu_mode_lo_pos];
        end
        else if (wake_event)
        begin
            cpu_mode_reg <= cpu_mode_normal;
        end
        else if (ctrl_write && state_reg == st_run
            && reg_wdata[cpu_mode_hi_pos:cpu_mode_lo_pos] != 2'h3)
        begin
            // The reserved code 11 is treated as no request.
            cpu_mode_reg <=
                reg_wdata[cpu_mode_hi_pos:cpu_mode_lo_pos];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operating-mode sequencer. Green keeps clock_mode_reg, so its wake
    // returns to whichever of normal or slow was active before.

    // Power-down hears only the port; green also hears the basic timer.
    assign pd_wake = (state_reg == st_power_down) && port_wake;
    assign green_wake = (state_reg == st_green)
        && (port_wake || timer_overflow);
    assign wake_event = pd_wake || green_wake;
    assign ready_event = (state_reg == st_warm) && fast_osc_tick
        && (warm_cnt_reg == warm_target_reg - 12'h1);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= st_warm;
        end
        else
        begin
            unique case (state_reg)
                st_warm:
                begin
                    if (ready_event)
                    begin
                        state_reg <= st_run;
                    end
                end
                st_run:
                begin
                    // The core may take one more instruction in the cycle
                    // between the mode write and the state change.
                    if (cpu_mode_reg == cpu_mode_power_down)
                    begin
                        state_reg <= st_power_down;
                    end
                    else if (cpu_mode_reg == cpu_mode_green)
                    begin
                        state_reg <= st_green;
                    end
                end
                st_green:
                begin
                    if (wake_event)
                    begin
                        state_reg <= st_run;
                    end
                end
                st_power_down:
                begin
                    if (wake_event)
                    begin
                        state_reg <= st_warm;
                    end
                end
            endcase
        end
    end

    // Warm-up counter counts high-speed oscillator clocks, not sys_clk.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            warm_cnt_reg <= 12'h0;
        end
        else if (pd_wake)
        begin
            warm_cnt_reg <= 12'h0;
        end
        else if (state_reg == st_warm && fast_osc_tick)
        begin
            warm_cnt_reg <= warm_cnt_reg + 12'h1;
        end
    end

    // Reset always waits the long count; a power-down wake waits the
    // count that suits the oscillator type, since RC types start fast.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            warm_target_reg <= 12'(warm_reset_clocks);
        end
        else if (pd_wake)
        begin
            warm_target_reg <= osc_is_rc ? 12'(warm_rc_clocks)
                : 12'(warm_xtal_clocks);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock and enable outputs.

    always_comb
    begin
        clock_ctrl.cpu_run = (state_reg == st_run);
        clock_ctrl.sys_clk_slow = clock_mode_reg;
        // Slow mode does not stop the fast oscillator by itself.
        clock_ctrl.fast_osc_on = (state_reg == st_warm)
            || ((state_reg != st_power_down)
                && !high_osc_stop_reg);
        clock_ctrl.slow_rc_on = watchdog_enabled
            || (state_reg != st_power_down);
        // With the RTC option the 32768 Hz crystal ignores the stop bit.
        clock_ctrl.rtc_xtal_on = (rtc_option && osc_is_internal)
            && (state_reg != st_power_down);
        clock_ctrl.timers_on = (state_reg == st_run)
            || (state_reg == st_green);
        clock_ctrl.interrupts_on = (state_reg != st_power_down);
        clock_ctrl.serial_clock_on = (state_reg == st_run)
            && !clock_mode_reg;
    end

    // The slow path fires once per divided slow period; the fast path
    // needs the oscillator running, so a stop bit in normal mode
    // starves the core of instruction clocks.
    assign slow_cpu_tick = slow_rc_tick
        && (slow_div_cnt_reg == 3'(slow_div_ratio - 1));
    assign fast_cpu_tick = fast_osc_tick && !high_osc_stop_reg;

    always_comb
    begin
        if (state_reg != st_run)
        begin
            cpu_tick = 1'b0;
        end
        else if (clock_mode_reg)
        begin
            cpu_tick = slow_cpu_tick;
        end
        else
        begin
            cpu_tick = fast_cpu_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags, mask and interrupt. Write one to clear.

    assign irq_clear = (reg_wr && reg_addr == irq_status_addr)
        ? reg_wdata[1:0] : 2'h0;
    assign irq_set = {ready_event, wake_event};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq_mask_reg <= irq_reset;
        end
        else if (reg_wr && reg_addr == irq_mask_addr)
        begin
            irq_mask_reg <= reg_wdata[1:0];
        end
    end

    // A flag set in the same cycle as its clear stays set, so an event
    // that lands during the service write is never lost.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq_status_reg <= irq_reset;
        end
        else
        begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        // Reads have no side effects; flags clear only by a write.
        else if (reg_rd)
        begin
            unique case (reg_addr)
                osc_mode_ctrl_addr: reg_rdata <= ctrl_read;
                irq_status_addr: reg_rdata <= {6'h00, irq_status_reg};
                irq_mask_addr: reg_rdata <= {6'h00, irq_mask_reg};
                osc_status_addr: reg_rdata <= {4'h0, state_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : system_clock_mode_control

// >>> sim/clock_mode_chk.sv
// Port checker for the clock and operating-mode controller.
// Assumes it is bound to the controller and sees only its ports.
`timescale 1ns/10ps
module clock_mode_chk
    import clock_mode_pkg::*;
#(
    parameter logic watchdog_enabled = 1'b1
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic port_wake,
    input wire logic cpu_tick,
    input wire clock_ctrl_t clock_ctrl
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Mode writes only count while the core runs; others are refused.
    wire mode_wr = reg_wr && reg_addr == osc_mode_ctrl_addr
        && clock_ctrl.cpu_run;
    ////////////////////////////////////////////////////////////////////
    sequence s_pd_req;
        mode_wr && reg_wdata[4:3] == cpu_mode_power_down;
    endsequence
    sequence s_pd_in;
        ##[1:2] !clock_ctrl.cpu_run && !clock_ctrl.timers_on;
    endsequence
    property p_pd_entry;
        s_pd_req |-> s_pd_in;
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down not entered");
    property p_rdata;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data outside its cycle");
    property p_reset;
        $fell(rst) |-> !clock_ctrl.cpu_run && clock_ctrl.fast_osc_on;
    endproperty
    a_reset: assert property (p_reset)
        else $error("core runs before warm-up");
    property p_serial;
        !clock_ctrl.cpu_run || clock_ctrl.sys_clk_slow
            |-> !clock_ctrl.serial_clock_on;
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial clock on in slow mode");
    property p_pd_all;
        !clock_ctrl.timers_on && !clock_ctrl.fast_osc_on
            |-> !clock_ctrl.cpu_run && !clock_ctrl.interrupts_on;
    endproperty
    a_pd_all: assert property (p_pd_all)
        else $error("power-down leaves core running");
    property p_cpu_tick;
        cpu_tick |-> clock_ctrl.cpu_run;
    endproperty
    a_cpu_tick: assert property (p_cpu_tick)
        else $error("instruction clock while halted");
    property p_slow_rc;
        watchdog_enabled |-> clock_ctrl.slow_rc_on;
    endproperty
    a_slow_rc: assert property (p_slow_rc)
        else $error("slow oscillator stopped with watchdog");
    property p_slow_sel;
        mode_wr && reg_wdata == 8'h04
            |-> ##[1:2] clock_ctrl.sys_clk_slow && clock_ctrl.fast_osc_on;
    endproperty
    a_slow_sel: assert property (p_slow_sel)
        else $error("slow mode select wrong");
    property p_wake;
        !clock_ctrl.timers_on && port_wake |-> ##[1:2]
            clock_ctrl.fast_osc_on && !clock_ctrl.sys_clk_slow;
    endproperty
    a_wake: assert property (p_wake)
        else $error("power-down wake not to normal");
endmodule : clock_mode_chk

bind system_clock_mode_control clock_mode_chk #(
    .watchdog_enabled(watchdog_enabled)
) chk_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .port_wake(port_wake),
    .cpu_tick(cpu_tick),
    .clock_ctrl(clock_ctrl)
);

// >>> sim/osc_core_model.sv
// Model of the oscillators and core beside the controller.
// Assumes the fast oscillator ticks once a cycle while it is enabled.
`timescale 1ns/10ps
module osc_core_model
    import clock_mode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire clock_ctrl_t clock_ctrl,
    input wire logic cpu_tick,
    output logic fast_osc_tick,
    output logic [15:0] instr_count
);
    // A stopped oscillator gives no ticks, so warm-up cannot end early.
    always_ff @(posedge sys_clk)
    begin
        fast_osc_tick <= clock_ctrl.fast_osc_on;
    end
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            instr_count <= 16'h0000;
        else if (cpu_tick)
            instr_count <= instr_count + 16'h0001;
    end
endmodule : osc_core_model

// >>> sim/tb.sv
// Self-checking bench for the clock and mode controller.
// Assumes the oscillator model ticks every cycle.
`timescale 1ns/10ps
module tb;
    import clock_mode_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic port_wake = 1'b0;
    logic timer_overflow = 1'b0;
    logic [7:0] reg_rdata;
    logic fast_osc_tick;
    logic cpu_tick;
    logic slow_rc_tick;
    logic irq;
    logic [15:0] instr_count;
    clock_ctrl_t clock_ctrl;
    int n_fail = 0;
    int comparisons = 0;
    always #5 sys_clk = ~sys_clk;
    system_clock_mode_control #(.slow_div_ratio(1), .osc_is_rc(1'b1),
        .osc_is_internal(1'b1), .rtc_option(1'b0),
        .watchdog_enabled(1'b1)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fast_osc_tick(fast_osc_tick), .port_wake(port_wake),
        .timer_overflow(timer_overflow), .cpu_tick(cpu_tick),
        .slow_rc_tick(slow_rc_tick), .clock_ctrl(clock_ctrl), .irq(irq));
    osc_core_model model_u (.sys_clk(sys_clk), .rst(rst),
        .clock_ctrl(clock_ctrl), .cpu_tick(cpu_tick),
        .fast_osc_tick(fast_osc_tick), .instr_count(instr_count));
    ////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask : chk1
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, e);
    endtask : rdchk
    task automatic pulse(input logic wake);
        @(posedge sys_clk);
        port_wake <= wake;
        timer_overflow <= !wake;
        @(posedge sys_clk);
        port_wake <= 1'b0;
        timer_overflow <= 1'b0;
        #1;
    endtask : pulse
    task automatic wait_run(output int n);
        n = 0;
        while (clock_ctrl.cpu_run !== 1'b1 && n < 3000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask : wait_run
    ////////////////////////////////////////////////////////////////////
    task automatic t_warm;
        int n;
        logic [15:0] cnt;
        wr(osc_mode_ctrl_addr, 8'h04);
        rdchk(osc_mode_ctrl_addr, 8'h00);
        rdchk(osc_status_addr, 8'h01);
        rdchk(8'h00, 8'h00);
        wait_run(n);
        chk1(n > 1990 && n < 2060, 1'b1);
        rdchk(osc_status_addr, 8'h02);
        cnt = instr_count;
        repeat (10) @(posedge sys_clk);
        #1;
        chk8(8'(instr_count - cnt), 8'h0a);
        wr(irq_status_addr, 8'h03);
        rdchk(irq_status_addr, 8'h00);
    endtask : t_warm
    task automatic t_regs;
        wr(osc_mode_ctrl_addr, 8'hff);
        rdchk(osc_mode_ctrl_addr, 8'h06);
        chk1(clock_ctrl.fast_osc_on, 1'b0);
        chk1(clock_ctrl.slow_rc_on, 1'b1);
        chk1(clock_ctrl.sys_clk_slow, 1'b1);
        chk1(clock_ctrl.serial_clock_on, 1'b0);
        chk1(clock_ctrl.rtc_xtal_on, 1'b0);
        wr(osc_mode_ctrl_addr, 8'h04);
        chk1(clock_ctrl.fast_osc_on, 1'b1);
    endtask : t_regs
    task automatic t_green;
        int n;
        wr(irq_mask_addr, 8'h01);
        wr(osc_mode_ctrl_addr, 8'h14);
        repeat (3) @(posedge sys_clk);
        #1;
        chk1(clock_ctrl.cpu_run, 1'b0);
        chk1(clock_ctrl.timers_on, 1'b1);
        pulse(1'b0);
        wait_run(n);
        chk1(n < 40, 1'b1);
        rdchk(osc_mode_ctrl_addr, 8'h04);
        chk1(irq, 1'b1);
        wr(irq_status_addr, 8'h03);
        chk1(irq, 1'b0);
    endtask : t_green
    task automatic t_pd;
        int n;
        logic [15:0] cnt;
        wr(osc_mode_ctrl_addr, 8'h0e);
        repeat (3) @(posedge sys_clk);
        #1;
        cnt = instr_count;
        chk1(clock_ctrl.fast_osc_on, 1'b0);
        chk1(clock_ctrl.timers_on, 1'b0);
        chk1(clock_ctrl.slow_rc_on, 1'b1);
        chk1(clock_ctrl.interrupts_on, 1'b0);
        pulse(1'b0);
        repeat (10) @(posedge sys_clk);
        #1;
        chk1(clock_ctrl.cpu_run, 1'b0);
        chk8(instr_count[7:0], cnt[7:0]);
        pulse(1'b1);
        wait_run(n);
        chk1(n > 25 && n < 45, 1'b1);
        rdchk(osc_mode_ctrl_addr, 8'h00);
        chk1(irq, 1'b1);
        wr(irq_mask_addr, 8'h00);
        chk1(irq, 1'b0);
        wr(irq_mask_addr, 8'h01);
        chk1(irq, 1'b1);
        wr(irq_status_addr, 8'h01);
        chk1(irq, 1'b0);
    endtask : t_pd
    task automatic t_slow_tick;
        int n;
        logic [15:0] cnt;
        wr(osc_mode_ctrl_addr, 8'h04);
        n = 0;
        while (slow_rc_tick !== 1'b1 && n < 7000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        cnt = instr_count;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (slow_rc_tick !== 1'b1 && n < 7000);
        chk1(n == slow_rc_div, 1'b1);
        chk8(8'(instr_count - cnt), 8'h01);
    endtask : t_slow_tick
    task automatic finish_test;
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        t_warm();
        t_regs();
        t_green();
        t_pd();
        t_slow_tick();
        finish_test();
    end
    // Whole run is near 12500 cycles; the limit leaves over twice that.
    initial
    begin
        #300000;
        n_fail++;
        finish_test();
    end
endmodule : tb
